// file: dv/pcs_mdio_master.sv
/*
  Station management master model driving framed register accesses.
  Assumes one system clock and a pulled-up shared data line.
*/
`timescale 1ns/1ns
module pcs_mdio_master (
  // Clock
  input  wire logic clk,
  // Management pins
  output logic      mdc,
  output logic      mdioIn,
  input  wire logic mdioOut,
  input  wire logic mdioOe
);
  logic drvEn;
  logic drvVal;

  // Released line floats to the pull-up level
  assign mdioIn = mdioOe ? mdioOut : (drvEn ? drvVal : 1'h1);

  initial begin
    mdc    = 1'h0;
    drvEn  = 1'h0;
    drvVal = 1'h0;
  end

  // ****************************************
  // One management clock period
  // ****************************************
  // Five clk per phase keeps well clear of the synchroniser limits
  task automatic send(input logic en, input logic b, output logic s);
    drvEn  = en;
    drvVal = b;
    repeat (5) @(posedge clk);
    #1 s = mdioIn;
    mdc = 1'h1;
    repeat (5) @(posedge clk);
    #1 mdc = 1'h0;
  endtask : send

  // ****************************************
  // Whole frame
  // ****************************************
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic        s;
    logic        wr;
    hdr = {2'h1, op, pa, ra};
    wr  = (op == 2'h1);
    // Idle clock so a release and the next drive never share a time step
    @(posedge clk);
    #1;
    for (int i = 0; i < 32; i++) send(1'h1, 1'h1, s);
    for (int i = 13; i >= 0; i--) send(1'h1, hdr[i], s);
    send(wr, 1'h1, s);
    send(wr, 1'h0, s);
    for (int i = 15; i >= 0; i--) begin
      send(wr, wd[i], s);
      rd[i] = s;
    end
    drvEn = 1'h0;
  endtask : frame
endmodule : pcs_mdio_master

// file: dv/pcs_regbank_tb_top.sv
/*
  Self-checking bench of the register bank: table of frames, mode sweep, rejected frames, then a reset case.
  Assumes pcs_pkg compiled first and the master model beside it.
*/
`timescale 1ns/1ns
module pcs_regbank_tb_top;
  import pcs_pkg::*;

  typedef struct packed {
    logic        wr;
    logic [4:0]  ra;
    logic [15:0] wd;
    logic [15:0] ex;
    pcs_status_s st;
    logic [9:0]  ct;
  } pcs_row_s;

  localparam logic [4:0]  ADDR = 5'h05;
  localparam pcs_status_s STA  = {1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 3'h6, 9'h1a5};
  localparam pcs_status_s STB  = {1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 3'h5, 9'h05a};
  localparam pcs_row_s ROWS [17] = '{
    '{1'h0, 5'h1f, 16'h0000, 16'ha100, STA, 10'h320},
    '{1'h1, 5'h1f, 16'hffff, 16'h0000, STA, 10'h3fe},
    '{1'h0, 5'h1f, 16'h0000, 16'hef3f, STB, 10'h3fe},
    '{1'h1, 5'h1f, 16'h0000, 16'h0000, STB, 10'h000},
    '{1'h0, 5'h1f, 16'h0000, 16'h0000, STA, 10'h000},
    '{1'h1, 5'h1e, 16'hffff, 16'h0000, STA, 10'h001},
    '{1'h0, 5'h00, 16'h0000, 16'h0400, STA, 10'h001},
    '{1'h0, 5'h1e, 16'h0000, 16'h032e, STA, 10'h001},
    '{1'h1, 5'h00, 16'h0000, 16'h0000, STB, 10'h000},
    '{1'h0, 5'h1e, 16'h0000, 16'h0095, STB, 10'h000},
    '{1'h1, 5'h1d, 16'hffff, 16'h0000, STA, 10'h000},
    '{1'h0, 5'h1d, 16'h0000, 16'h01a5, STA, 10'h000},
    '{1'h0, 5'h05, 16'h0000, 16'h0000, STA, 10'h000},
    '{1'h1, 5'h1f, 16'h0210, 16'h0000, STA, 10'h000},
    '{1'h0, 5'h1f, 16'h0000, 16'h0210, STA, 10'h000},
    '{1'h1, 5'h1f, 16'h0020, 16'h0000, STA, 10'h000},
    '{1'h1, 5'h1f, 16'h2000, 16'h0000, STA, 10'h100}
  };

  logic        clk;
  logic        arst_n;
  logic        mdc;
  logic        mdioIn;
  logic        mdioOut;
  logic        mdioOe;
  logic        pairSwapStrap;
  pcs_status_s stat;
  logic        intReq;
  logic        speed100;
  logic        activity;
  pcs_ctrl_s   ctrlOut;
  logic        txOnPairB;
  logic        intPin;
  logic        indicatorOutZero;
  logic        indicatorOutOne;
  logic [15:0] rd;
  logic [15:0] sh;
  logic [1:0]  led;
  pcs_row_s    r;
  int          nMismatch;
  int          checksDone;
  int          cyc = 0;

  pcs_regbank uut (
    .clk(clk), .arst_n(arst_n), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut),
    .mdioOe(mdioOe), .pairSwapStrap(pairSwapStrap), .phyAddrStrap(ADDR), .stat(stat),
    .intReq(intReq), .speed100(speed100), .activity(activity), .ctrlOut(ctrlOut),
    .txOnPairB(txOnPairB), .intPin(intPin), .indicatorOutZero(indicatorOutZero),
    .indicatorOutOne(indicatorOutOne)
  );

  pcs_mdio_master mm (
    .clk(clk), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe)
  );

  // ****************************************
  // Clock, timeout, compares
  // ****************************************
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  // About 28 frames of 640 clk each, with margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      nMismatch++;
      reportAndStop();
    end
  end

  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : reportAndStop

  task automatic cmp16(input logic [15:0] a, input logic [15:0] e);
    checksDone++;
    if (a !== e) begin
      nMismatch++;
      $display("BAD %0t read word %h expected %h", $time, a, e);
    end
  endtask : cmp16

  task automatic cmp10(input logic [9:0] a, input logic [9:0] e);
    checksDone++;
    if (a !== e) begin
      nMismatch++;
      $display("BAD %0t control bits %h expected %h", $time, a, e);
    end
  endtask : cmp10

  task automatic cmp1(input logic a, input logic e);
    checksDone++;
    if (a !== e) begin
      nMismatch++;
      $display("BAD %0t pin %b expected %b", $time, a, e);
    end
  endtask : cmp1

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    nMismatch = 0;
    checksDone = 0;
    arst_n = 1'h0;
    pairSwapStrap = 1'h1;
    stat = STA;
    intReq = 1'h0;
    speed100 = 1'h0;
    activity = 1'h0;
    sh = 16'ha100;
    repeat (2) @(posedge clk);
    #1 arst_n = 1'h1;
    repeat (4) @(posedge clk);
    #1;
    for (int k = 0; k < 17; k++) begin
      r = ROWS[k];
      stat = r.st;
      intReq = k[0];
      activity = k[1];
      speed100 = k[2];
      mm.frame(r.wr ? 2'h1 : 2'h2, ADDR, r.ra, r.wd, rd);
      if (r.wr && r.ra == 5'h1f) sh = r.wd & 16'hef3f;
      repeat (2) @(posedge clk);
      #1;
      led = (sh[5:4] == 2'h0) ? {speed100, r.st.linkUp & ~activity} :
            (sh[5:4] == 2'h1) ? {activity, r.st.linkUp} : 2'h0;
      if (!r.wr) cmp16(rd, r.ex);
      cmp10(ctrlOut, r.ct);
      cmp1(txOnPairB, sh[13] ? sh[14] : r.st.crossState);
      cmp1(intPin, sh[9] ? intReq : ~intReq);
      cmp1(indicatorOutZero, led[0]);
      cmp1(indicatorOutOne, led[1]);
    end
    // Every mode code, reserved ones too, passes through unchanged
    for (int m = 0; m < 8; m++) begin
      stat = STA;
      stat.opMode = m[2:0];
      mm.frame(2'h2, ADDR, 5'h1e, 16'h0000, rd);
      cmp16(rd, 16'h0320 | {13'h0, m[2:0]});
    end
    // Foreign address and illegal opcode leave the bank untouched
    mm.frame(2'h1, 5'h06, 5'h1f, 16'hffff, rd);
    mm.frame(2'h3, ADDR, 5'h1f, 16'hffff, rd);
    cmp10(ctrlOut, 10'h100);
    // Mid-run reset with the strap low
    pairSwapStrap = 1'h0;
    arst_n = 1'h0;
    repeat (2) @(posedge clk);
    #1 arst_n = 1'h1;
    repeat (4) @(posedge clk);
    #1 cmp10(ctrlOut, 10'h220);
    mm.frame(2'h2, ADDR, 5'h1f, 16'h0000, rd);
    cmp16(rd, 16'h8100);
    reportAndStop();
  end
endmodule : pcs_regbank_tb_top

// file: verilog/pcs_pkg.sv
/*
  Types of the PHY control/status register bank.
  Assumes pcs_regs.svh is on the include path.
*/
package pcs_pkg;
  `include "pcs_regs.svh"

  // ****************************************
  // Management frame states
  // ****************************************
  typedef enum logic [2:0] {
    PCS_PRE   = 3'b000,
    PCS_START = 3'b001,
    PCS_HDR   = 3'b010,
    PCS_TA    = 3'b011,
    PCS_DATA  = 3'b100
  } pcs_state_e;

  // ****************************************
  // Live status from the transceiver core
  // ****************************************
  typedef struct packed {
    logic       pauseCapable;
    logic       linkUp;
    logic       polarityRev;
    logic       crossState;
    logic       energyDet;
    logic [2:0] opMode;
    logic [8:0] faultDist;
  } pcs_status_s;

  // ****************************************
  // Control bits to the transceiver core
  // ****************************************
  typedef struct packed {
    logic       altCrossoverMode;
    logic       autoXoverDis;
    logic       forceLink;
    logic       powerSave;
    logic       jabberEn;
    logic       txDisable;
    logic       remoteLoop;
    logic       sqeTest;
    logic       scramBypass;
    logic       isolate;
  } pcs_ctrl_s;
endpackage : pcs_pkg

// file: verilog/pcs_regbank.sv
/*
  PHY control/status register bank with its management frame slave.
  Assumes mdc, mdio and straps come from pins; status and event inputs
  come from transceiver logic on clk. MDC must stay well below clk/4.
*/
`timescale 1ns/1ns
`include "pcs_regs.svh"
module pcs_regbank
  import pcs_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Management pins
  input  wire logic        mdc,
  input  wire logic        mdioIn,
  output logic             mdioOut,
  output logic             mdioOe,
  // Straps
  input  wire logic        pairSwapStrap,
  input  wire logic [4:0]  phyAddrStrap,
  // Core status and events
  input  wire pcs_status_s stat,
  input  wire logic        intReq,
  input  wire logic        speed100,
  input  wire logic        activity,
  // Core control
  output pcs_ctrl_s        ctrlOut,
  output logic             txOnPairB,
  output logic             intPin,
  output logic             indicatorOutZero,
  output logic             indicatorOutOne
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [7:0]  asyncIn;
  logic [7:0]  syncA_ff;
  logic [7:0]  syncB_ff;

  assign asyncIn = {phyAddrStrap, pairSwapStrap, mdioIn, mdc};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_sync
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          syncA_ff[gi] <= 1'b0;
          syncB_ff[gi] <= 1'b0;
        end else begin
          syncA_ff[gi] <= asyncIn[gi];
          syncB_ff[gi] <= syncA_ff[gi];
        end
      end
    end
  endgenerate

  logic        mdcPrev_ff;
  logic        mdcRise;
  logic        mdioBit;

  assign mdcRise = syncB_ff[0] & ~mdcPrev_ff;
  assign mdioBit = syncB_ff[1];

  // ****************************************
  // Strap capture after reset release
  // ****************************************
  logic [1:0]  strapCnt_ff;
  logic        strapLoad;
  logic [4:0]  phyAddr_ff;

  // Synchronised straps are valid only after two edges
  assign strapLoad = (strapCnt_ff == `PCS_STRAP_WAIT);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strapCnt_ff <= 2'h0;
      phyAddr_ff  <= 5'h00;
      mdcPrev_ff  <= 1'b0;
    end else begin
      strapCnt_ff <= (strapCnt_ff == 2'h3) ? strapCnt_ff : strapCnt_ff + 2'h1;
      phyAddr_ff  <= strapLoad ? syncB_ff[7:3] : phyAddr_ff;
      mdcPrev_ff  <= syncB_ff[0];
    end
  end

  // ****************************************
  // Frame slave
  // ****************************************
  pcs_state_e  state_ff;
  pcs_state_e  nxt_state;
  logic [5:0]  cnt_ff;
  logic [5:0]  nxt_cnt;
  logic [11:0] hdr_ff;
  logic [11:0] nxt_hdr;
  logic [15:0] data_ff;
  logic [15:0] nxt_data;
  logic        mdioOe_ff;
  logic        nxt_oe;
  logic        mdioOut_ff;
  logic        nxt_out;
  logic [15:0] rdMux;

  wire         isRead  = (hdr_ff[11:10] == `PCS_OP_READ);
  wire  [4:0]  regAd   = hdr_ff[4:0];
  wire         frameOk = ((nxt_hdr[11:10] == `PCS_OP_READ) ||
                          (nxt_hdr[11:10] == `PCS_OP_WRITE)) &&
                         (nxt_hdr[9:5] == phyAddr_ff);
  wire         wrEn    = mdcRise && (state_ff == PCS_DATA) && !isRead &&
                         (cnt_ff == `PCS_DATA_LAST);
  wire  [15:0] wrData  = {data_ff[14:0], mdioBit};

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_hdr   = {hdr_ff[10:0], mdioBit};
    nxt_data  = data_ff;
    nxt_oe    = mdioOe_ff;
    nxt_out   = mdioOut_ff;
    if (mdcRise) begin
      case (state_ff)
        PCS_PRE: begin
          if (mdioBit) begin
            nxt_cnt = (cnt_ff == `PCS_PREAMBLE_LEN) ? cnt_ff : cnt_ff + 6'h01;
          end else begin
            nxt_cnt   = 6'h00;
            nxt_state = (cnt_ff == `PCS_PREAMBLE_LEN) ? PCS_START : PCS_PRE;
          end
        end
        PCS_START: begin
          nxt_state = mdioBit ? PCS_HDR : PCS_PRE;
        end
        PCS_HDR: begin
          if (cnt_ff == `PCS_HDR_LAST) begin
            nxt_cnt   = 6'h00;
            // Frames for another address are ignored
            nxt_state = frameOk ? PCS_TA : PCS_PRE;
          end else begin
            nxt_cnt = cnt_ff + 6'h01;
          end
        end
        PCS_TA: begin
          if (cnt_ff == 6'h00) begin
            nxt_cnt = 6'h01;
            if (isRead) begin
              nxt_oe   = 1'b1;
              nxt_out  = 1'b0;
              nxt_data = rdMux; // R18
            end
          end else begin
            nxt_cnt   = 6'h00;
            nxt_state = PCS_DATA;
            if (isRead) begin
              nxt_out  = data_ff[15];
              nxt_data = {data_ff[14:0], 1'b0};
            end
          end
        end
        PCS_DATA: begin
          if (isRead) begin
            nxt_out  = data_ff[15];
            nxt_data = {data_ff[14:0], 1'b0};
          end else begin
            nxt_data = wrData;
          end
          if (cnt_ff == `PCS_DATA_LAST) begin
            nxt_state = PCS_PRE;
            nxt_cnt   = 6'h00;
            nxt_oe    = 1'b0;
            nxt_out   = 1'b0;
          end else begin
            nxt_cnt = cnt_ff + 6'h01;
          end
        end
        default: begin
          nxt_state = PCS_PRE;
          nxt_cnt   = 6'h00;
          nxt_oe    = 1'b0;
        end
      endcase
    end
  end

  // Header shifts only while it is being received
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff   <= PCS_PRE;
      cnt_ff     <= 6'h00;
      hdr_ff     <= 12'h000;
      data_ff    <= 16'h0000;
      mdioOe_ff  <= 1'b0;
      mdioOut_ff <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      hdr_ff     <= (mdcRise && state_ff == PCS_HDR) ? nxt_hdr : hdr_ff;
      data_ff    <= nxt_data;
      mdioOe_ff  <= nxt_oe;
      mdioOut_ff <= nxt_out;
    end
  end

  assign mdioOe  = mdioOe_ff;
  assign mdioOut = mdioOut_ff;

  // ****************************************
  // Register storage
  // ****************************************
  logic [15:0] ctrl2_ff;
  logic        isolate_ff;
  logic [15:0] rdCtrl1;
  logic [15:0] rdDiag;
  logic [15:0] rdBasic;

  wire wrCtrl2 = wrEn && (regAd == `PCS_REG_CTRL2);
  wire wrBasic = wrEn && (regAd == `PCS_REG_BASIC);
  wire wrCtrl1 = wrEn && (regAd == `PCS_REG_CTRL1);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl2_ff   <= `PCS_CTRL2_RST; // R6 R10 R11 R12 R16
      isolate_ff <= 1'b0;
    end else begin
      if (wrCtrl2) begin
        ctrl2_ff <= wrData & `PCS_CTRL2_WMASK; // R18
      end else if (strapLoad) begin
        ctrl2_ff[`PCS_C2_XDIS_BIT] <= syncB_ff[2]; // R8
      end
      // Either location updates the one bit
      if (wrBasic) begin
        isolate_ff <= wrData[`PCS_BASIC_ISO_BIT]; // R4
      end else if (wrCtrl1) begin
        isolate_ff <= wrData[`PCS_C1_ISO_BIT]; // R4
      end
    end
  end

  // Live status is sampled at turnaround, never latched earlier
  assign rdCtrl1 = {6'h00, stat.pauseCapable, stat.linkUp, stat.polarityRev, // R1 R2
                    1'b0, stat.crossState, stat.energyDet, isolate_ff,       // R2 R3
                    stat.opMode};                                            // R5
  assign rdDiag  = {7'h00, stat.faultDist}; // R19
  assign rdBasic = {5'h00, isolate_ff, 10'h000}; // R4
  assign rdMux   = (regAd == `PCS_REG_CTRL2) ? ctrl2_ff :
                   (regAd == `PCS_REG_CTRL1) ? rdCtrl1  :
                   (regAd == `PCS_REG_DIAG)  ? rdDiag   :
                   (regAd == `PCS_REG_BASIC) ? rdBasic  : 16'h0000; // R18

  // ****************************************
  // Control outputs
  // ****************************************
  assign ctrlOut.altCrossoverMode = ctrl2_ff[`PCS_C2_ALTX_BIT];  // R6
  assign ctrlOut.autoXoverDis     = ctrl2_ff[`PCS_C2_XDIS_BIT];  // R8
  assign ctrlOut.forceLink        = ctrl2_ff[`PCS_C2_FLINK_BIT]; // R9
  assign ctrlOut.powerSave        = ctrl2_ff[`PCS_C2_PSAVE_BIT]; // R10
  assign ctrlOut.jabberEn         = ctrl2_ff[`PCS_C2_JAB_BIT];   // R12
  assign ctrlOut.txDisable        = ctrl2_ff[`PCS_C2_TXDIS_BIT]; // R14
  assign ctrlOut.remoteLoop       = ctrl2_ff[`PCS_C2_RLOOP_BIT]; // R15
  assign ctrlOut.sqeTest          = ctrl2_ff[`PCS_C2_SQE_BIT];   // R16
  assign ctrlOut.scramBypass      = ctrl2_ff[`PCS_C2_SCRBY_BIT]; // R17
  assign ctrlOut.isolate          = isolate_ff;                  // R4

  wire       intHigh = ctrl2_ff[`PCS_C2_INTLVL_BIT];
  wire [1:0] ledMode = ctrl2_ff[`PCS_C2_LED_HI:`PCS_C2_LED_LO];
  wire       nxt_pairB = ctrl2_ff[`PCS_C2_XDIS_BIT] ? ctrl2_ff[`PCS_C2_MDIX_BIT]
                                                     : stat.crossState; // R7
  // Reserved modes keep both indicators dark
  wire       nxt_ind0 = (ledMode == 2'h0) ? (stat.linkUp & ~activity) :
                        (ledMode == 2'h1) ? stat.linkUp : 1'b0; // R13
  wire       nxt_ind1 = (ledMode == 2'h0) ? speed100 :
                        (ledMode == 2'h1) ? activity : 1'b0; // R13

  logic      txOnPairB_ff;
  logic      intPin_ff;
  logic      ind0_ff;
  logic      ind1_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txOnPairB_ff <= 1'b0;
      intPin_ff    <= 1'b1;
      ind0_ff      <= 1'b0;
      ind1_ff      <= 1'b0;
    end else begin
      txOnPairB_ff <= nxt_pairB;
      intPin_ff    <= intHigh ? intReq : ~intReq; // R11
      ind0_ff      <= nxt_ind0;
      ind1_ff      <= nxt_ind1;
    end
  end

  assign txOnPairB        = txOnPairB_ff;
  assign intPin           = intPin_ff;
  assign indicatorOutZero = ind0_ff;
  assign indicatorOutOne  = ind1_ff;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  wire loadRd = mdcRise && (state_ff == PCS_TA) && (cnt_ff == 6'h00) && isRead;

  sequence s_turn;
    loadRd;
  endsequence
  sequence s_drive0;
    mdioOe && !mdioOut;
  endsequence

  property p_pause;
    s_turn and (regAd == `PCS_REG_CTRL1) |=> data_ff[9] == $past(stat.pauseCapable);
  endproperty
  a_pause: assert property (p_pause) else $error("pause flag wrong"); // R1

  property p_live;
    s_turn and (regAd == `PCS_REG_CTRL1) |=>
      data_ff[8] == $past(stat.linkUp) && data_ff[7] == $past(stat.polarityRev) &&
      data_ff[5] == $past(stat.crossState) && data_ff[6] == 1'b0;
  endproperty
  a_live: assert property (p_live) else $error("live flags wrong"); // R2

  property p_energy;
    s_turn and (regAd == `PCS_REG_CTRL1) |=> data_ff[4] == $past(stat.energyDet);
  endproperty
  a_energy: assert property (p_energy) else $error("energy flag wrong"); // R3

  property p_isoShared;
    wrBasic |=> ctrlOut.isolate == $past(wrData[`PCS_BASIC_ISO_BIT]);
  endproperty
  a_isoShared: assert property (p_isoShared) else $error("isolate not shared"); // R4

  property p_mode;
    s_turn and (regAd == `PCS_REG_CTRL1) |=>
      data_ff[2:0] == $past(stat.opMode) && data_ff[3] == $past(isolate_ff);
  endproperty
  a_mode: assert property (p_mode) else $error("mode field wrong"); // R5

  property p_xover;
    ctrlOut.autoXoverDis |=> txOnPairB == $past(ctrl2_ff[`PCS_C2_MDIX_BIT]);
  endproperty
  a_xover: assert property (p_xover) else $error("manual swap ignored"); // R7

  property p_strap;
    strapLoad && !wrCtrl2 |=> ctrlOut.autoXoverDis == $past(syncB_ff[2]);
  endproperty
  a_strap: assert property (p_strap) else $error("strap not loaded"); // R8

  property p_intPol;
    ##1 intPin == ($past(intReq) ~^ $past(intHigh));
  endproperty
  a_intPol: assert property (p_intPol) else $error("interrupt polarity"); // R11

  property p_rsvd;
    ctrl2_ff[12] == 1'b0 && ctrl2_ff[7:6] == 2'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set"); // R18

  property p_turnDrive;
    s_turn |=> s_drive0 ##1 s_drive0;
  endproperty
  a_turnDrive: assert property (p_turnDrive) else $error("no turnaround"); // R18

  property p_dist;
    s_turn and (regAd == `PCS_REG_DIAG) |=>
      data_ff == {7'h00, $past(stat.faultDist)};
  endproperty
  a_dist: assert property (p_dist) else $error("distance wrong"); // R19

endmodule : pcs_regbank

// file: verilog/pcs_regs.svh
/*
  Offsets, field positions, reset values and frame counts of the PHY
  control/status register bank, as macros.
  Assumes inclusion by pcs_pkg and the bank module only.
*/
// Overview of operation
// R1 - Read-only pause capability flag, resets to zero
// R2 - Live link, polarity and crossover state flags
// R3 - Energy flag follows receive pair signal presence
// R4 - One isolate bit shared by two registers
// R5 - Three-bit resolved speed/duplex mode field
// R6 - Alternate crossover algorithm select, default one
// R7 - Manual pair swap when auto crossover off
// R8 - Auto crossover disable, reset from strap
// R9 - Force link bypasses link control logic
// R10 - Power saving enable, reset zero
// R11 - Interrupt pin polarity select, default low
// R12 - Jabber counter enable, default on
// R13 - Two-bit indicator mode field
// R14 - Transmitter disable bit
// R15 - Remote analog loopback enable
// R16 - SQE test enable, reset zero
// R17 - Scrambler bypass bit
// R18 - Live reads, read-only ignored, reserved zero
// R19 - Nine-bit fault distance count, resets zero
`ifndef PCS_REGS_SVH
`define PCS_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define PCS_REG_BASIC      5'h00
`define PCS_REG_DIAG       5'h1d
`define PCS_REG_CTRL1      5'h1e
`define PCS_REG_CTRL2      5'h1f

// ****************************************
// Field positions
// ****************************************
`define PCS_BASIC_ISO_BIT  10
`define PCS_C1_ISO_BIT     3
`define PCS_C2_ALTX_BIT    15
`define PCS_C2_MDIX_BIT    14
`define PCS_C2_XDIS_BIT    13
`define PCS_C2_FLINK_BIT   11
`define PCS_C2_PSAVE_BIT   10
`define PCS_C2_INTLVL_BIT  9
`define PCS_C2_JAB_BIT     8
`define PCS_C2_LED_HI      5
`define PCS_C2_LED_LO      4
`define PCS_C2_TXDIS_BIT   3
`define PCS_C2_RLOOP_BIT   2
`define PCS_C2_SQE_BIT     1
`define PCS_C2_SCRBY_BIT   0

// ****************************************
// Reset values and masks
// ****************************************
`define PCS_CTRL2_RST      16'h8100
`define PCS_CTRL2_WMASK    16'hef3f

// ****************************************
// Management frame
// ****************************************
`define PCS_PREAMBLE_LEN   6'h20
`define PCS_HDR_LAST       6'h0b
`define PCS_DATA_LAST      6'h0f
`define PCS_OP_READ        2'h2
`define PCS_OP_WRITE       2'h1
`define PCS_STRAP_WAIT     2'h2

`endif
